// File: bwc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module bwc_ctrl
  import bwc_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // pins from outside
  input wire logic [MODE_W-1:0] mode_select_pins,
  input wire logic nmi_n,
  input wire logic int_n,
  // core side
  input wire logic internal_irq,
  input wire logic global_irq_enable_flag,
  input wire logic halt_loop,
  input wire logic sleep_instruction,
  input wire logic io_stop_set,
  input wire logic io_stop_clear,
  input wire logic cyc_start,
  input wire logic cyc_rom,
  input wire logic cyc_ext_io,
  input wire logic cyc_onchip,
  input wire logic [1:0] onchip_sel,
  input wire logic wait_cnt_wr,
  input wire logic [1:0] wait_cnt_wdata,
  input wire logic [ADDR_W-1:0] core_addr,
  input wire logic [7:0] core_dout,
  input wire logic core_drive,
  input wire logic core_rd_n,
  input wire logic core_wr_n,
  input wire logic core_mem_n,
  input wire logic core_io_n,
  input wire logic [PORT_W-1:0] port_out,
  // status to core
  output logic [MODE_W-1:0] op_mode,
  output logic [1:0] wait_cnt,
  output logic cyc_ready,
  output logic irq_ack,
  output logic resume_next,
  output logic cpu_stopped,
  output logic io_stopped,
  // bus pins
  output logic [ADDR_W-1:0] addr_o,
  output logic addr_oe_n,
  output logic [7:0] data_o,
  output logic data_oe_n,
  output logic rd_n,
  output logic wr_n,
  output logic memory_select_strobe_n,
  output logic io_select_strobe_n,
  output logic halt_n,
  output logic bus_grant_acknowledge_n,
  output logic transfer_end_strobe_n,
  output logic periph_enable,
  output logic clk_out,
  output logic [PORT_W-1:0] port_pins
);
  // --------------------------------------------------
  // state
  // --------------------------------------------------
  typedef struct packed
  {
    logic [1:0] settle;
    logic [MODE_W-1:0] op_mode;
    logic [1:0] wait_cnt;
    bwc_pwr_e pwr;
    bwc_cyc_e cyc;
    logic [2:0] wcount;
    logic cyc_ready;
    logic irq_ack;
    logic resume_next;
    logic io_stopped;
    logic [ADDR_W-1:0] addr_o;
    logic addr_oe_n;
    logic [7:0] data_o;
    logic data_oe_n;
    logic rd_n;
    logic wr_n;
    logic mem_n;
    logic io_n;
    logic halt_n;
    logic periph_enable;
    logic grant_ack_n;
    logic xfer_end_n;
    logic cpu_stopped;
    logic [PORT_W-1:0] port_pins;
  } bwc_state_s;

  bwc_state_s r;
  bwc_state_s next_r;
  logic [MODE_W-1:0] mode_sync;
  logic nmi_req;
  logic int_req;
  logic clk_div;
  logic next_clk_div;
  logic ext_irq;
  logic any_irq;
  logic [2:0] need;
  logic [2:0] onchip_w;

  // --------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------
  bwc_sync #(.W(MODE_W + 2)) u_sync
  (
    .clk_sys(clk_sys),
    .reset(reset),
    // irq pins enter inverted so the cleared flops read as no request
    .d({mode_select_pins, ~nmi_n, ~int_n}),
    .q({mode_sync, nmi_req, int_req})
  );

  assign ext_irq = nmi_req || int_req;
  assign any_irq = ext_irq || internal_irq;
  assign onchip_w = ONCHIP_WAIT_TABLE[3*onchip_sel +: 3];

  // --------------------------------------------------
  // next state
  // --------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.irq_ack = 1'b0;
    next_r.resume_next = 1'b0;
    next_r.cyc_ready = 1'b0;
    next_r.grant_ack_n = 1'b1;
    next_r.xfer_end_n = 1'b1;
    // an unknown start falls into the else and sets the divider going
    if (clk_div)
    begin
      next_clk_div = 1'b0;
    end
    else
    begin
      next_clk_div = 1'b1;
    end
    need = {1'b0, r.wait_cnt};
    // straps sampled while the synchroniser refills after release; never again
    if (r.settle != MODE_SETTLE)
    begin
      next_r.op_mode = mode_sync;
      next_r.settle = r.settle + 2'h1;
    end
    if (wait_cnt_wr)
    begin
      next_r.wait_cnt = wait_cnt_wdata;
    end
    // set wins over software clear
    if (io_stop_clear)
    begin
      next_r.io_stopped = 1'b0;
    end
    if (io_stop_set)
    begin
      next_r.io_stopped = 1'b1;
    end
    if (cyc_rom)
    begin
      need = (r.op_mode == MODE_ROM_WAIT) ? {1'b0, r.wait_cnt} : 3'h0;
    end
    else if (cyc_ext_io)
    begin
      need = ({1'b0, r.wait_cnt} < IO_EXT_MIN_WAIT) ? IO_EXT_MIN_WAIT : {1'b0, r.wait_cnt};
    end
    else if (cyc_onchip)
    begin
      need = (onchip_w > ONCHIP_MAX_WAIT) ? ONCHIP_MAX_WAIT : onchip_w;
    end
    case (r.cyc)
      BWC_IDLE:
      begin
        if (cyc_start && r.pwr == BWC_RUN)
        begin
          next_r.wcount = need;
          next_r.cyc = (need == 3'h0) ? BWC_DONE : BWC_WAIT;
        end
      end
      BWC_WAIT:
      begin
        next_r.wcount = r.wcount - 3'h1;
        if (r.wcount == 3'h1)
        begin
          next_r.cyc = BWC_DONE;
        end
      end
      BWC_DONE:
      begin
        next_r.cyc_ready = 1'b1;
        next_r.cyc = BWC_IDLE;
      end
      default:
      begin
        next_r.cyc = BWC_IDLE;
      end
    endcase
    case (r.pwr)
      BWC_RUN:
      begin
        if (sleep_instruction)
        begin
          next_r.pwr = r.io_stopped ? BWC_SYSSTOP : BWC_SLEEP;
        end
        else if (halt_loop && any_irq && global_irq_enable_flag)
        begin
          next_r.irq_ack = 1'b1;
        end
      end
      BWC_SLEEP:
      begin
        if (any_irq)
        begin
          next_r.pwr = BWC_RUN;
          next_r.irq_ack = global_irq_enable_flag;
          next_r.resume_next = !global_irq_enable_flag;
        end
      end
      BWC_SYSSTOP:
      begin
        if (ext_irq)
        begin
          next_r.pwr = BWC_RUN;
          next_r.irq_ack = global_irq_enable_flag;
          next_r.resume_next = !global_irq_enable_flag;
        end
      end
      default:
      begin
        next_r.pwr = BWC_RUN;
      end
    endcase
    // bus pins follow the core unless asleep
    if (next_r.pwr != BWC_RUN)
    begin
      next_r.addr_o = ADDR_SLEEP;
      next_r.addr_oe_n = 1'b0;
      next_r.data_oe_n = 1'b1;
      next_r.rd_n = 1'b1;
      next_r.wr_n = 1'b1;
      next_r.mem_n = 1'b1;
      next_r.io_n = 1'b1;
      next_r.halt_n = 1'b1;
    end
    else
    begin
      next_r.addr_o = core_addr;
      next_r.addr_oe_n = 1'b0;
      next_r.data_o = core_dout;
      next_r.data_oe_n = !core_drive;
      next_r.rd_n = core_rd_n;
      next_r.wr_n = core_wr_n;
      next_r.mem_n = core_mem_n;
      next_r.io_n = core_io_n;
      next_r.halt_n = !halt_loop;
      next_r.port_pins = port_out;
    end
    // ports hold their last level through sleep
    if (next_r.pwr != BWC_RUN)
    begin
      next_r.port_pins = r.port_pins;
    end
    next_r.periph_enable = 1'b1;
    next_r.cpu_stopped = (next_r.pwr != BWC_RUN);
  end

  // --------------------------------------------------
  // registers; reset shows the float and idle pattern
  // --------------------------------------------------
  // reset length itself is the outside's job
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      r <= '0;
      r.wait_cnt <= WAIT_CNT_RESET;
      r.pwr <= BWC_RUN;
      r.cyc <= BWC_IDLE;
      r.addr_oe_n <= 1'b1;
      r.data_oe_n <= 1'b1;
      r.rd_n <= 1'b1;
      r.wr_n <= 1'b1;
      r.mem_n <= 1'b1;
      r.io_n <= 1'b1;
      r.halt_n <= 1'b1;
      r.periph_enable <= 1'b0;
      r.grant_ack_n <= 1'b1;
      r.xfer_end_n <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  // no reset: the clock output has to keep running while reset is held
  always_ff @(posedge clk_sys)
  begin
    clk_div <= next_clk_div;
  end
  assign op_mode = r.op_mode;
  assign wait_cnt = r.wait_cnt;
  assign cyc_ready = r.cyc_ready;
  assign irq_ack = r.irq_ack;
  assign resume_next = r.resume_next;
  assign io_stopped = r.io_stopped;
  assign cpu_stopped = r.cpu_stopped;
  assign addr_o = r.addr_o;
  assign addr_oe_n = r.addr_oe_n;
  assign data_o = r.data_o;
  assign data_oe_n = r.data_oe_n;
  assign rd_n = r.rd_n;
  assign wr_n = r.wr_n;
  assign memory_select_strobe_n = r.mem_n;
  assign io_select_strobe_n = r.io_n;
  assign halt_n = r.halt_n;
  assign bus_grant_acknowledge_n = r.grant_ack_n;
  assign transfer_end_strobe_n = r.xfer_end_n;
  assign periph_enable = r.periph_enable;
  assign clk_out = clk_div;
  assign port_pins = r.port_pins;
endmodule : bwc_ctrl
`default_nettype wire

// File: bwc_pkg.sv
package bwc_pkg;
  // --------------------------------------------------
  // bus and mode constants
  // --------------------------------------------------
  localparam int ADDR_W = 20;
  localparam logic [19:0] ADDR_SLEEP = 20'hfffff;
  localparam logic [1:0] WAIT_CNT_RESET = 2'h3;
  localparam logic [2:0] IO_EXT_MIN_WAIT = 3'h1;
  localparam logic [2:0] ONCHIP_MAX_WAIT = 3'h4;
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_ROM_WAIT = 2'h2;
  // strap samples taken after release; the last one has crossed the synchroniser
  localparam logic [1:0] MODE_SETTLE = 2'h3;
  localparam int ONCHIP_DEVS = 4;
  localparam int PORT_W = 8;
  // per peripheral on-chip wait: async serial, clocked serial, timer data, other
  localparam logic [11:0] ONCHIP_WAIT_TABLE = {3'h0, 3'h4, 3'h3, 3'h2};
  // --------------------------------------------------
  // types
  // --------------------------------------------------
  typedef enum logic [1:0]
  {
    BWC_RUN = 2'h0,
    BWC_SLEEP = 2'h1,
    BWC_SYSSTOP = 2'h2
  } bwc_pwr_e;
  typedef enum logic [1:0]
  {
    BWC_IDLE = 2'h0,
    BWC_WAIT = 2'h1,
    BWC_DONE = 2'h2
  } bwc_cyc_e;
endpackage : bwc_pkg

// File: bwc_sync.sv
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------
// two-flop synchroniser for a group of pin levels
// --------------------------------------------------
module bwc_sync #(parameter int W = 1)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : bwc_sync
`default_nettype wire

// File: bwc_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// checker
// ----
module bwc_sva
  import bwc_pkg::*;
(
  // watched ports, grouped to keep the list short
  input wire logic clk_sys, reset, internal_irq, global_irq_enable_flag, halt_loop, nmi_n, int_n,
  input wire logic io_stop_clear, cyc_start, cyc_ext_io, cyc_onchip, cyc_ready, irq_ack, cpu_stopped,
  input wire logic io_stopped, addr_oe_n, data_oe_n, rd_n, wr_n, memory_select_strobe_n, halt_n,
  input wire logic io_select_strobe_n, periph_enable, bus_grant_acknowledge_n, transfer_end_strobe_n,
  input wire logic [1:0] onchip_sel, wait_cnt,
  input wire logic [MODE_W-1:0] op_mode,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic [PORT_W-1:0] port_pins
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_go;
    cyc_start && !cpu_stopped;
  endsequence
  sequence s_ext_go;
    s_go ##0 cyc_ext_io && wait_cnt == 2'h0;
  endsequence
  sequence s_timer_go;
    s_go ##0 cyc_onchip && onchip_sel == 2'h2;
  endsequence
  AST_HALT_ACK: assert property (halt_loop && internal_irq && global_irq_enable_flag && !cpu_stopped
    |=> irq_ack) else $error("halt interrupt not taken");
  // straps are resampled for three edges after release while the synchroniser refills
  AST_MODE_FIXED: assert property (!$past(reset) && !$past(reset, 2) && !$past(reset, 3)
    && !$past(reset, 4) |-> $stable(op_mode)) else $error("mode moved after reset");
  AST_PORT_HOLD: assert property (cpu_stopped && $past(cpu_stopped) |-> $stable(port_pins))
    else $error("port moved in sleep");
  AST_EXT_WAIT: assert property (s_ext_go |=> !cyc_ready ##1 !cyc_ready ##1 cyc_ready)
    else $error("io cycle without one wait");
  AST_TIMER_WAIT: assert property (s_timer_go |-> ##6 cyc_ready)
    else $error("timer access not four waits");
  AST_RESET_BUS: assert property (disable iff (1'b0) reset |-> addr_oe_n && data_oe_n && rd_n && wr_n
    && memory_select_strobe_n && io_select_strobe_n && halt_n && !periph_enable
    && bus_grant_acknowledge_n && transfer_end_strobe_n) else $error("bus not parked in reset");
  AST_SLEEP_BUS: assert property (cpu_stopped |-> addr_o == ADDR_SLEEP && rd_n && wr_n
    && memory_select_strobe_n && io_select_strobe_n && halt_n) else $error("sleep bus wrong");
  AST_STOP_STAYS: assert property ((cpu_stopped && io_stopped && nmi_n && int_n) [*3] |=> cpu_stopped)
    else $error("left system stop without pin");
  AST_IO_STAYS: assert property (io_stopped && !io_stop_clear |=> io_stopped)
    else $error("io stop dropped");
endmodule : bwc_sva
bind bwc_ctrl bwc_sva u_sva (.*);
`default_nettype wire

// File: bwc_bus_dev.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// far side io device, counts io strobes only
// ----
module bwc_bus_dev
(
  input wire logic clk_sys,
  input wire logic io_select_strobe_n,
  output logic [7:0] io_hits
);
  // no read data path exists in the block, so nothing is answered
  initial io_hits = 8'h0;
  always @(posedge clk_sys)
    if (!io_select_strobe_n)
      io_hits <= io_hits + 8'h1;
endmodule : bwc_bus_dev
`default_nettype wire

// File: tb_bus_wait_reset_lowpower_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module tb_bus_wait_reset_lowpower_ctrl;
  import bwc_pkg::*;
  // ----
  // signals
  // ----
  logic clk_sys = 1'b0, reset, nmi_n = 1'b1, int_n = 1'b1, internal_irq = 1'b0, halt_loop = 1'b0;
  logic global_irq_enable_flag = 1'b0, sleep_instruction = 1'b0, io_stop_set = 1'b0, io_stop_clear = 1'b0;
  logic cyc_start = 1'b0, cyc_rom = 1'b0, cyc_ext_io = 1'b0, cyc_onchip = 1'b0, wait_cnt_wr = 1'b0;
  logic core_drive = 1'b0, core_rd_n = 1'b1, core_wr_n = 1'b1, core_mem_n = 1'b1, core_io_n = 1'b1;
  logic [1:0] onchip_sel = 2'h0, wait_cnt_wdata = 2'h0, wait_cnt, mode_select_pins = 2'h1, op_mode;
  logic [ADDR_W-1:0] core_addr = 20'h12345, addr_o;
  logic [7:0] core_dout = 8'h3c, data_o, io_hits, port_out = 8'ha5, port_pins;
  logic cyc_ready, irq_ack, resume_next, cpu_stopped, io_stopped, addr_oe_n, data_oe_n, rd_n, wr_n, clk_out;
  logic memory_select_strobe_n, io_select_strobe_n, halt_n, bus_grant_acknowledge_n, transfer_end_strobe_n;
  logic periph_enable;
  int error_cnt = 0, tests_run = 0;
  bwc_ctrl dut (.*);
  bwc_bus_dev u_dev (.clk_sys(clk_sys), .io_select_strobe_n(io_select_strobe_n), .io_hits(io_hits));
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  // raised after time zero so the asynchronous reset surely sees an edge
  initial #1 reset = 1'b1;
  // ----
  // helpers
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tk
  // one bus cycle; ready shows just after the edge need+1 after the taking edge
  task automatic bus(input logic [2:0] kind, input logic [1:0] s, input int need);
    int k;
    k = 0;
    @(posedge clk_sys);
    {cyc_rom, cyc_ext_io, cyc_onchip, onchip_sel} <= {kind, s};
    core_io_n <= !kind[1];
    cyc_start <= 1'b1;
    @(posedge clk_sys);
    cyc_start <= 1'b0;
    while (k < 20 && cyc_ready !== 1'b1)
    begin
      tk(1);
      k++;
    end
    chk(k, need + 1);
  endtask : bus
  task automatic set_wait(input logic [1:0] v);
    @(posedge clk_sys);
    wait_cnt_wdata <= v;
    wait_cnt_wr <= 1'b1;
    @(posedge clk_sys);
    wait_cnt_wr <= 1'b0;
    tk(2);
    chk(wait_cnt, v);
  endtask : set_wait
  // bounded wait for a one-cycle pulse: 1 irq_ack, 0 resume_next
  task automatic wait_hi(input logic which);
    int k;
    k = 0;
    while (k < 12 && (which ? irq_ack : resume_next) !== 1'b1)
    begin
      tk(1);
      k++;
    end
    chk(k < 12, 1'b1);
  endtask : wait_hi
  task automatic final_report;
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // ----
  // scenarios
  // ----
  task automatic t_mode;
    logic prev;
    tk(2);
    chk({addr_oe_n, data_oe_n, rd_n, wr_n, periph_enable, wait_cnt}, 7'h7b);
    @(posedge clk_sys) reset <= 1'b0;
    tk(3);
    chk(op_mode, 2'h1);
    bus(3'b100, 2'h0, 0);
    @(posedge clk_sys) mode_select_pins <= MODE_ROM_WAIT;
    tk(4);
    chk(op_mode, 2'h1);
    // held seven cycles, as the outside must
    @(posedge clk_sys) reset <= 1'b1;
    tk(3);
    prev = clk_out;
    tk(1);
    chk(clk_out, !prev);
    tk(2);
    @(posedge clk_sys) reset <= 1'b0;
    tk(3);
    chk(op_mode, MODE_ROM_WAIT);
    chk(wait_cnt, WAIT_CNT_RESET);
    $display("mode test done");
  endtask : t_mode
  task automatic t_bus;
    bus(3'b100, 2'h0, 3);
    bus(3'b010, 2'h0, 3);
    chk(io_hits != 8'h0, 1'b1);
    set_wait(2'h0);
    bus(3'b100, 2'h0, 0);
    bus(3'b010, 2'h0, 1);
    for (int i = 0; i < ONCHIP_DEVS; i++)
      bus(3'b001, i[1:0], ONCHIP_WAIT_TABLE[i*3 +: 3]);
    $display("bus test done");
  endtask : t_bus
  task automatic t_halt;
    @(posedge clk_sys) {halt_loop, internal_irq, global_irq_enable_flag} <= 3'h7;
    tk(2);
    chk(irq_ack, 1'b1);
    @(posedge clk_sys) global_irq_enable_flag <= 1'b0;
    tk(2);
    chk(irq_ack, 1'b0);
    @(posedge clk_sys) {halt_loop, internal_irq} <= 2'h0;
    $display("halt test done");
  endtask : t_halt
  task automatic t_sleep;
    @(posedge clk_sys) sleep_instruction <= 1'b1;
    @(posedge clk_sys) sleep_instruction <= 1'b0;
    port_out <= 8'h5a;
    tk(3);
    chk(port_pins, 8'ha5);
    chk({addr_o, rd_n, wr_n, memory_select_strobe_n, io_select_strobe_n}, {ADDR_SLEEP, 4'hf});
    @(posedge clk_sys) internal_irq <= 1'b1;
    wait_hi(1'b0);
    chk(cpu_stopped, 1'b0);
    @(posedge clk_sys) internal_irq <= 1'b0;
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_stop;
    @(posedge clk_sys) io_stop_set <= 1'b1;
    @(posedge clk_sys) io_stop_set <= 1'b0;
    sleep_instruction <= 1'b1;
    @(posedge clk_sys) sleep_instruction <= 1'b0;
    internal_irq <= 1'b1;
    tk(6);
    chk({cpu_stopped, io_stopped}, 2'h3);
    @(posedge clk_sys) {int_n, internal_irq, global_irq_enable_flag} <= 3'h1;
    wait_hi(1'b1);
    @(posedge clk_sys) int_n <= 1'b1;
    tk(2);
    chk(io_stopped, 1'b1);
    @(posedge clk_sys) io_stop_clear <= 1'b1;
    @(posedge clk_sys) io_stop_clear <= 1'b0;
    tk(2);
    chk(io_stopped, 1'b0);
    $display("stop test done");
  endtask : t_stop
  initial
  begin
    t_mode();
    t_bus();
    t_halt();
    t_sleep();
    t_stop();
    final_report();
  end
  // about 100 cycles are needed; this allows far more
  initial
  begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule : tb_bus_wait_reset_lowpower_ctrl
`default_nettype wire
